// *** inc/bpan_consts.svh ***
`ifndef BPAN_CONSTS_SVH
`define BPAN_CONSTS_SVH

// clock and timing
`define BPAN_CLK_PERIOD_NS 10
`define BPAN_BREAK_LINK_US 60000
`define BPAN_INHIBIT_US 500000
`define BPAN_TIMER_W 26
// lane and DME rates, in units of 10 kb/s and 10 kHz
`define BPAN_LANE_RATE_10K 2578125
`define BPAN_DME_CLK_10K 31250
`define BPAN_REPEAT_LO 7'h52
`define BPAN_REPEAT_HI 7'h53
// frame layout
`define BPAN_PAGE_W 48
`define BPAN_FRAME_BITS 6'h31
`define BPAN_RAND_POS 6'h30
`define BPAN_ACK_FRAMES 4'h8
`define BPAN_TECH_N 4
// signal detect window and threshold
`define BPAN_SD_WINDOW 8'hff
`define BPAN_SD_MIN_EDGES 8'h40
// link control codes
`define BPAN_LC_OFF 2'h0
`define BPAN_LC_SCAN 2'h1
`define BPAN_LC_MISSION 2'h3
// selector field value
`define BPAN_SELECTOR 5'h01
// register port
`define BPAN_ADDR_W 4
`define BPAN_REG_CTRL 4'h0
`define BPAN_REG_STATUS 4'h4
`define BPAN_REG_LP_LO 4'h8
`define BPAN_REG_LP_HI 4'hc
`define BPAN_CTRL_RESTART 0
`define BPAN_CTRL_TRAIN_EN 1
`define BPAN_CTRL_RESET 2'h2

`endif

// *** inc/bpan_pkg.sv ***
package bpan_pkg;
  // one 48-bit base page
  typedef struct packed {
    logic [1:0] fecBits;
    logic trainAbility;
    logic [3:0] tech;
    logic [19:0] spare;
    logic [4:0] txNonce;
    logic np;
    logic ack;
    logic rf;
    logic [2:0] pause;
    logic [4:0] echoNonce;
    logic [4:0] selector;
  } bpan_page_type;

  // results reported on completion
  typedef struct packed {
    logic done;
    logic fecOn;
    logic txPauseOn;
    logic rxPauseOn;
  } bpan_result_type;

  typedef enum logic [2:0] {
    ST_ENABLE,
    ST_BREAK,
    ST_ABILITY,
    ST_ACK,
    ST_COMPLETE_ACK,
    ST_GOOD_CHECK,
    ST_TRAIN,
    ST_GOOD
  } bpan_state_type;
endpackage

// *** core/bpan_rand_bit.sv ***
`timescale 1ns/1ps
`include "bpan_consts.svh"

// random bit source for the spare frame position
module bpan_rand_bit (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] seed,
  input wire logic [1:0] polySelect,
  input wire logic load,
  input wire logic step,
  output logic randBit
);
  logic [15:0] shiftReg;
  logic feedback;

  // four tap sets; any choice is legal, none locks up when seeded non-zero
  always_comb
  begin
    case (polySelect)
      2'h0: feedback = shiftReg[15] ^ shiftReg[14] ^ shiftReg[12] ^ shiftReg[3];
      2'h1: feedback = shiftReg[15] ^ shiftReg[13] ^ shiftReg[12] ^ shiftReg[10];
      2'h2: feedback = shiftReg[15] ^ shiftReg[4] ^ shiftReg[2] ^ shiftReg[1];
      default: feedback = shiftReg[15] ^ shiftReg[11] ^ shiftReg[10] ^ shiftReg[8];
    endcase
  end

  // seed lands in both halves so a zero seed still leaves one bit set
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shiftReg <= 16'h0001;
    else if (load)
      shiftReg <= {seed, seed | 8'h01};
    else if (step)
      shiftReg <= {shiftReg[14:0], feedback};
  end

  assign randBit = shiftReg[15];
endmodule // bpan_rand_bit

// *** core/bpan_negotiation_engine.sv ***
`timescale 1ns/1ps
`include "bpan_consts.svh"

module bpan_negotiation_engine #(
  parameter int BREAK_CYCLES =
    `BPAN_BREAK_LINK_US * 1000 / `BPAN_CLK_PERIOD_NS,
  parameter int INHIBIT_CYCLES =
    `BPAN_INHIBIT_US * 1000 / `BPAN_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic negotiationEnable,
  input wire logic restartIn,
  input wire logic [`BPAN_TECH_N-1:0] abilityIn,
  input wire logic [1:0] fecAbilityIn,
  input wire logic pauseIn,
  input wire logic asmDirIn,
  input wire logic [7:0] nonceSeed,
  input wire logic [1:0] random_poly_select,
  input wire logic [`BPAN_TECH_N-1:0] linkStatusIn,
  output logic [2*`BPAN_TECH_N-1:0] linkControlOut,
  input wire logic laneRxLevel,
  input wire logic rxPageValid,
  input wire bpan_pkg::bpan_page_type rxPage,
  output logic laneTxLevel,
  output logic laneTxEnable,
  output logic [6:0] laneRepeat,
  input wire logic pcsRxStatus,
  output logic trainStart,
  input wire logic trainDone,
  output logic missionPath,
  output logic negotiation_done_out,
  output logic negotiated_fec_on,
  output logic txPauseEnable,
  output logic rxPauseEnable,
  input wire logic [`BPAN_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regReadData
);
  import bpan_pkg::*;

  bpan_state_type state;
  bpan_state_type next_state;
  logic [`BPAN_TIMER_W-1:0] timer;
  logic restartPrev;
  logic restartEdge;
  logic [1:0] ctrlReg;
  logic swRestart;
  bpan_page_type lpPage;
  bpan_page_type txPage;
  logic [`BPAN_TECH_N-1:0] common;
  logic [`BPAN_TECH_N-1:0] selTech;
  logic [`BPAN_TECH_N-1:0] next_selTech;
  bpan_result_type result;
  bpan_result_type next_result;
  logic trained;
  logic trainBoth;
  logic selStatus;
  logic [5:0] bitIdx;
  logic halfCell;
  logic frameEnd;
  logic [3:0] ackFrames;
  logic randBit;
  logic laneToggle;
  logic rxPrev;
  logic [7:0] sdWindow;
  logic [7:0] sdEdges;
  logic sigDetect;
  logic nonceClash;
  logic txActive;

  // lane 0 sees one DME half-cell per clock; the lane gearbox repeats it
  // 82 or 83 lane bits, alternating, giving 82.5 average
  localparam int LaneBitsPerTwoHalves =
    2 * `BPAN_LANE_RATE_10K / `BPAN_DME_CLK_10K;

  // restart edge and software restart, both one-cycle events
  assign restartEdge = restartIn & ~restartPrev;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      restartPrev <= 1'b0;
    else
      restartPrev <= restartIn;
  end

  // digital signal detect: a real partner toggles the line often, while
  // crosstalk seldom crosses the edge threshold in one window
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxPrev <= 1'b0;
      sdWindow <= 8'h00;
      sdEdges <= 8'h00;
      sigDetect <= 1'b0;
    end
    else
    begin
      rxPrev <= laneRxLevel;
      if (sdWindow == `BPAN_SD_WINDOW)
      begin
        sdWindow <= 8'h00;
        sdEdges <= 8'h00;
        sigDetect <= (sdEdges >= `BPAN_SD_MIN_EDGES);
      end
      else
      begin
        sdWindow <= sdWindow + 8'h01;
        if (laneRxLevel != rxPrev)
          sdEdges <= sdEdges + 8'h01;
      end
    end
  end

  // local page, rebuilt every cycle from the ability inputs, the control register, the partner nonce and the state
  always_comb
  begin
    txPage = '0;
    txPage.selector = `BPAN_SELECTOR;
    txPage.pause = {1'b0, asmDirIn, pauseIn};
    txPage.txNonce = nonceSeed[4:0];
    txPage.echoNonce = lpPage.txNonce;
    txPage.ack = (state == ST_ACK) || (state == ST_COMPLETE_ACK);
    txPage.tech = abilityIn;
    txPage.trainAbility = ctrlReg[`BPAN_CTRL_TRAIN_EN];
    txPage.fecBits = fecAbilityIn;
  end

  // identical nonces are not broken here: negotiation restarts forever
  assign nonceClash = (rxPage.txNonce == nonceSeed[4:0]);
  assign common = abilityIn & lpPage.tech;
  assign trainBoth = ctrlReg[`BPAN_CTRL_TRAIN_EN] & lpPage.trainAbility;
  assign selStatus = |(selTech & linkStatusIn);
  assign frameEnd = halfCell && (bitIdx == `BPAN_FRAME_BITS - 6'h01);
  assign txActive = (state == ST_ABILITY) || (state == ST_ACK) ||
    (state == ST_COMPLETE_ACK);

  // highest common technology wins; one-hot result
  always_comb
  begin
    next_selTech = '0;
    for (int i = 0; i < `BPAN_TECH_N; i++)
    begin
      if (common[i])
        next_selTech = '0;
      if (common[i])
        next_selTech[i] = 1'b1;
    end
  end

  // pause and FEC resolution from both pages
  always_comb
  begin
    next_result.done = 1'b1;
    next_result.fecOn = (|(fecAbilityIn & lpPage.fecBits)) &
      (fecAbilityIn[1] | lpPage.fecBits[1]);
    next_result.txPauseOn = (pauseIn & lpPage.pause[0]) |
      (asmDirIn & ~pauseIn & lpPage.pause[0] & lpPage.pause[1]);
    next_result.rxPauseOn = (pauseIn & lpPage.pause[0]) |
      (pauseIn & asmDirIn & ~lpPage.pause[0] & lpPage.pause[1]);
  end

  // arbitration sequence
  always_comb
  begin
    next_state = state;
    case (state)
      ST_ENABLE:
        if (negotiationEnable)
          next_state = ST_BREAK;
      ST_BREAK:
        if (timer >= `BPAN_TIMER_W'(BREAK_CYCLES - 1))
          next_state = ST_ABILITY;
      ST_ABILITY:
        if (rxPageValid && sigDetect)
          next_state = nonceClash ? ST_BREAK : ST_ACK;
      ST_ACK:
        if (rxPageValid && sigDetect && rxPage.ack)
          next_state = ST_COMPLETE_ACK;
      ST_COMPLETE_ACK:
        if (frameEnd && ackFrames == `BPAN_ACK_FRAMES - 4'h1)
          next_state = (|common) ? ST_GOOD_CHECK : ST_BREAK;
      ST_GOOD_CHECK:
        if (timer >= `BPAN_TIMER_W'(INHIBIT_CYCLES - 1))
          next_state = ST_BREAK;
        else if (trainBoth && !trained)
          next_state = ST_TRAIN;
        else if (pcsRxStatus && selStatus)
          next_state = ST_GOOD;
      ST_TRAIN:
        if (trainDone)
          next_state = ST_GOOD_CHECK;
        else if (timer >= `BPAN_TIMER_W'(INHIBIT_CYCLES - 1))
          next_state = ST_BREAK;
      ST_GOOD:
        if (!selStatus || !sigDetect)
          next_state = ST_BREAK;
      default:
        next_state = ST_ENABLE;
    endcase
    if (!negotiationEnable)
      next_state = ST_ENABLE;
    else if (restartEdge || swRestart)
      next_state = ST_BREAK;
  end

  // state register; reset lands in the idle state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_ENABLE;
    else
      state <= next_state;
  end

  // one timer, cleared on every state change
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      timer <= '0;
    else if (next_state != state)
      timer <= '0;
    else if (timer != '1)
      timer <= timer + `BPAN_TIMER_W'(1);
  end

  // partner page is captured once, on passing from ability detect to acknowledge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lpPage <= '0;
    else if (state == ST_ABILITY && next_state == ST_ACK)
      lpPage <= rxPage;
  end

  // training bookkeeping; start is a level held through training
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      trained <= 1'b0;
    else if (state == ST_BREAK)
      trained <= 1'b0;
    else if (state == ST_TRAIN && trainDone)
      trained <= 1'b1;
  end
  assign trainStart = (state == ST_TRAIN);

  // selection and results, held from resolution until the next break
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      selTech <= '0;
      result <= '0;
    end
    else if (next_state == ST_GOOD && state != ST_GOOD)
      result <= next_result;
    else if (state == ST_COMPLETE_ACK)
      selTech <= next_selTech;
    else if (next_state == ST_BREAK || next_state == ST_ENABLE)
    begin
      selTech <= '0;
      result <= '0;
    end
  end

  // results only reported; the datapath enables stay with the user
  assign negotiation_done_out = result.done;
  assign negotiated_fec_on = result.fecOn;
  assign txPauseEnable = result.txPauseOn;
  assign rxPauseEnable = result.rxPauseOn;

  // lane switches to the PCS only once everything has finished
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      missionPath <= 1'b0;
    else
      missionPath <= (next_state == ST_GOOD);
  end

  // per-technology link control
  genvar t;
  generate
    for (t = 0; t < `BPAN_TECH_N; t++)
    begin : gLinkCtl
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          linkControlOut[2*t+1:2*t] <= `BPAN_LC_OFF;
        else if (next_state == ST_ENABLE || next_state == ST_BREAK)
          linkControlOut[2*t+1:2*t] <= `BPAN_LC_OFF;
        else if (state == ST_GOOD_CHECK || state == ST_TRAIN ||
          state == ST_GOOD)
          linkControlOut[2*t+1:2*t] <=
            selTech[t] ? `BPAN_LC_MISSION : `BPAN_LC_OFF;
        else if (abilityIn[t])
          linkControlOut[2*t+1:2*t] <= `BPAN_LC_SCAN;
        else
          linkControlOut[2*t+1:2*t] <= `BPAN_LC_OFF;
      end
    end
  endgenerate

  // random bit for frame position 48; a new bit per frame
  bpan_rand_bit uRand (
    .clock(clock),
    .rst_n(rst_n),
    .seed(nonceSeed),
    .polySelect(random_poly_select),
    .load(state == ST_ENABLE),
    .step(frameEnd),
    .randBit(randBit)
  );

  // DME transmit: a transition opens every cell, a one adds one mid-cell
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitIdx <= 6'h00;
      halfCell <= 1'b0;
      laneTxLevel <= 1'b0;
      laneTxEnable <= 1'b0;
      ackFrames <= 4'h0;
    end
    else if (!txActive)
    begin
      bitIdx <= 6'h00;
      halfCell <= 1'b0;
      laneTxEnable <= 1'b0;
      ackFrames <= 4'h0;
    end
    else
    begin
      laneTxEnable <= 1'b1;
      halfCell <= ~halfCell;
      if (!halfCell)
        laneTxLevel <= ~laneTxLevel;
      else if (bitIdx == `BPAN_RAND_POS ? randBit : txPage[bitIdx])
        laneTxLevel <= ~laneTxLevel;
      if (halfCell)
        bitIdx <= frameEnd ? 6'h00 : bitIdx + 6'h01;
      if (frameEnd && state == ST_COMPLETE_ACK)
        ackFrames <= ackFrames + 4'h1;
    end
  end

  // repeat count alternates so two half-cells span 165 lane bits
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      laneToggle <= 1'b0;
    else
      laneToggle <= ~laneToggle;
  end
  assign laneRepeat = laneToggle ? `BPAN_REPEAT_HI :
    7'(LaneBitsPerTwoHalves - `BPAN_REPEAT_HI);

  // control register; restart bit is a write-only pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlReg <= `BPAN_CTRL_RESET;
      swRestart <= 1'b0;
    end
    else
    begin
      swRestart <= regWrite && regAddr == `BPAN_REG_CTRL &&
        regWriteData[`BPAN_CTRL_RESTART];
      if (regWrite && regAddr == `BPAN_REG_CTRL)
        ctrlReg <= regWriteData[1:0] & 2'h2;
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regReadData <= 32'h0;
    else if (!regRead)
      regReadData <= 32'h0;
    else
      case (regAddr)
        `BPAN_REG_CTRL: regReadData <= {30'h0, ctrlReg};
        `BPAN_REG_STATUS: regReadData <= {16'h0, selTech, 1'b0,
          state, sigDetect, trained, missionPath, 1'b0, result};
        `BPAN_REG_LP_LO: regReadData <= lpPage[31:0];
        `BPAN_REG_LP_HI: regReadData <= {16'h0, lpPage[47:32]};
        default: regReadData <= 32'h0;
      endcase
  end
endmodule // bpan_negotiation_engine

// *** verif/bpan_engine_monitor.sv ***
`timescale 1ns/1ps
`include "bpan_consts.svh"

// watches the engine's own ports only
module bpan_engine_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic negotiationEnable,
  input wire logic restartIn,
  input wire logic [`BPAN_TECH_N-1:0] abilityIn,
  input wire logic pcsRxStatus,
  input wire logic [2*`BPAN_TECH_N-1:0] linkControlOut,
  input wire logic trainStart,
  input wire logic missionPath,
  input wire logic negotiation_done_out,
  input wire logic negotiated_fec_on,
  input wire logic txPauseEnable,
  input wire logic rxPauseEnable
);
  logic [`BPAN_TECH_N-1:0] techActive;
  logic missionAny;

  // one flag per technology whose control pair is not off
  always_comb
  begin
    for (int t = 0; t < `BPAN_TECH_N; t++)
      techActive[t] = |linkControlOut[2*t +: 2];
  end
  // some pair carries the mission code 11
  assign missionAny = |(linkControlOut[6:0] & linkControlOut[7:1] & 7'h55);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence restartEdge;
    $rose(restartIn) && negotiationEnable;
  endsequence
  sequence heldOff;
    !negotiationEnable [*2];
  endsequence

  a_reset_idle: assert property (!$past(rst_n) |->
    !negotiation_done_out && linkControlOut == 8'h00 && !negotiated_fec_on)
    else $error("outputs not idle after reset");
  a_restart_break: assert property (restartEdge |->
    ##[1:2] linkControlOut == 8'h00)
    else $error("restart did not enter break link");
  a_disable_idle: assert property (heldOff |->
    !negotiation_done_out && linkControlOut == 8'h00)
    else $error("disabled engine not idle");
  a_done_needs_pcs: assert property ($rose(negotiation_done_out) |->
    $past(pcsRxStatus))
    else $error("done without pcs receive status");
  a_train_blocks_done: assert property (trainStart |->
    !negotiation_done_out)
    else $error("done raised during training");
  a_results_need_done: assert property ((negotiated_fec_on ||
    txPauseEnable || rxPauseEnable) |-> negotiation_done_out)
    else $error("result enable without completion");
  a_mission_code: assert property (negotiation_done_out |->
    missionAny)
    else $error("no mission code on completion");
  a_scan_abilities: assert property ((techActive & ~abilityIn) == 4'h0)
    else $error("control active for unadvertised technology");
  a_done_on_mission: assert property (negotiation_done_out |->
    missionPath)
    else $error("completed without mission path");
endmodule // bpan_engine_monitor

bind bpan_negotiation_engine bpan_engine_monitor mon (
  .clock(clock), .rst_n(rst_n), .negotiationEnable(negotiationEnable),
  .restartIn(restartIn), .abilityIn(abilityIn), .pcsRxStatus(pcsRxStatus),
  .linkControlOut(linkControlOut), .trainStart(trainStart),
  .missionPath(missionPath), .negotiation_done_out(negotiation_done_out),
  .negotiated_fec_on(negotiated_fec_on), .txPauseEnable(txPauseEnable),
  .rxPauseEnable(rxPauseEnable)
);

// *** verif/bpan_link_partner.sv ***
`timescale 1ns/1ps

// remote device: activity on lane 0 and one decoded page per frame
module bpan_link_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic active,
  input wire logic farTxOn,
  input wire bpan_pkg::bpan_page_type pageIn,
  output logic laneRxLevel,
  output logic rxPageValid,
  output bpan_pkg::bpan_page_type rxPage
);
  import bpan_pkg::*;
  logic [6:0] cellCount;
  logic [3:0] pageCount;

  // half-cell toggling on lane 0; a silent partner leaves no energy
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      laneRxLevel <= 1'b0;
    else
      laneRxLevel <= active & ~laneRxLevel;
  end

  // 49 bits of two half-cells per frame; ack only from the third page
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cellCount <= 7'h00;
      pageCount <= 4'h0;
      rxPageValid <= 1'b0;
      rxPage <= '0;
    end
    else
    begin
      rxPageValid <= 1'b0;
      rxPage <= ~rxPage; // page inverted every cycle between frames
      if (!active || !farTxOn)
      begin
        cellCount <= 7'h00;
        pageCount <= 4'h0;
      end
      else if (cellCount == 7'h61)
      begin
        cellCount <= 7'h00;
        pageCount <= pageCount + {3'h0, pageCount != 4'hf};
        rxPageValid <= 1'b1;
        rxPage <= pageIn;
        rxPage.ack <= pageCount >= 4'h2;
      end
      else
        cellCount <= cellCount + 7'h01;
    end
  end
endmodule // bpan_link_partner

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "bpan_consts.svh"

module tb_top;
  import bpan_pkg::*;
  localparam logic [7:0] SEED = 8'h5a;
  logic clock, rst_n, negotiationEnable, restartIn, pcsRxStatus, trainDone;
  logic [1:0] polySel;
  logic [3:0] linkStatus, regAddr;
  logic [31:0] regWriteData, regReadData;
  logic regWrite, regRead, partnerOn, laneRxLevel, rxPageValid;
  logic [7:0] linkControlOut;
  logic laneTxEnable, trainStart, missionPath, negotiation_done_out;
  logic negotiated_fec_on, txPauseEnable, rxPauseEnable;
  logic laneTxLevel, asmDir;
  logic [6:0] laneRepeat;
  bpan_page_type page, rxPage;
  int mismatches, checked, cycles;

  // short break and inhibit timers keep the run brief
  bpan_negotiation_engine #(.BREAK_CYCLES(200), .INHIBIT_CYCLES(2000)) dut (
    .clock(clock), .rst_n(rst_n), .negotiationEnable(negotiationEnable),
    .restartIn(restartIn), .abilityIn(4'h5), .fecAbilityIn(2'h3),
    .pauseIn(1'b1), .asmDirIn(asmDir), .nonceSeed(SEED),
    .random_poly_select(polySel), .linkStatusIn(linkStatus),
    .linkControlOut(linkControlOut), .laneRxLevel(laneRxLevel),
    .rxPageValid(rxPageValid), .rxPage(rxPage),
    .laneTxLevel(laneTxLevel), .laneTxEnable(laneTxEnable),
    .laneRepeat(laneRepeat), .pcsRxStatus(pcsRxStatus),
    .trainStart(trainStart), .trainDone(trainDone),
    .missionPath(missionPath), .negotiation_done_out(negotiation_done_out),
    .negotiated_fec_on(negotiated_fec_on), .txPauseEnable(txPauseEnable),
    .rxPauseEnable(rxPauseEnable), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData));

  bpan_link_partner partner (.clock(clock), .rst_n(rst_n),
    .active(partnerOn), .farTxOn(laneTxEnable), .pageIn(page),
    .laneRxLevel(laneRxLevel), .rxPageValid(rxPageValid), .rxPage(rxPage));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard; a full run needs about 12000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: return linkControlOut === 8'h11;
      1: return trainStart === 1'b1;
      2: return negotiation_done_out === 1'b1;
      default: return negotiation_done_out === 1'b0;
    endcase
  endfunction

  task automatic wait_until(input int sel);
    for (int n = 0; n < 5000 && !cond(sel); n++)
    begin
      @(posedge clock);
      #1;
    end
    check(32'(cond(sel)), 32'h1);
  endtask

  task automatic test_reset();
    logic [31:0] d;
    logic [6:0] r0;
    reg_read(4'h0, d);
    check(d, 32'h2);
    reg_read(4'h4, d);
    check(d, 32'h0);
    reg_read(4'h2, d);
    check(d, 32'h0);
    // two half-cells must span 165 lane bits in any phase
    r0 = laneRepeat;
    @(posedge clock);
    #1 check(32'(r0) + 32'(laneRepeat), 32'ha5);
    $display("test reset finished");
  endtask

  task automatic test_negotiate(input logic [1:0] sel);
    logic [31:0] d;
    polySel <= sel;
    pcsRxStatus <= 1'b0;
    linkStatus <= 4'h0;
    trainDone <= 1'b0;
    restartIn <= 1'b1;
    @(posedge clock);
    restartIn <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check(32'(linkControlOut), 32'h0);
    wait_until(0);
    wait_until(1);
    trainDone <= 1'b1;
    repeat (20) @(posedge clock);
    #1 check(32'(negotiation_done_out), 32'h0);
    pcsRxStatus <= 1'b1;
    linkStatus <= 4'h4;
    wait_until(2);
    check(32'(negotiated_fec_on), 32'h1);
    check(32'(txPauseEnable), 32'h1);
    check(32'(rxPauseEnable), 32'h1);
    check(32'(linkControlOut[5:4]), 32'h3);
    check(32'(missionPath), 32'h1);
    reg_read(4'h4, d);
    check(32'({d[15:12], d[3:0]}), 32'h4f);
    reg_read(4'hc, d);
    check(d, 32'h6c00);
    $display("test negotiate %0d finished", sel);
  endtask

  // losing the partner's energy must drop the link and start over
  task automatic test_carrier_loss();
    partnerOn <= 1'b0;
    wait_until(3);
    partnerOn <= 1'b1;
    wait_until(0);
    wait_until(2);
    $display("test carrier loss finished");
  endtask

  task automatic test_no_training();
    logic [31:0] d;
    reg_write(4'h0, 32'h1);
    reg_read(4'h0, d);
    check(d, 32'h0);
    wait_until(3);
    wait_until(2);
    reg_read(4'h4, d);
    check(32'(d[6]), 32'h0);
    $display("test no training finished");
  endtask

  task automatic test_equal_nonce();
    int rises, flips;
    logic prevTx, seenDone, prevLevel;
    rises = 0;
    flips = 0;
    prevTx = 1'b1;
    prevLevel = laneTxLevel;
    seenDone = 1'b0;
    page.txNonce <= SEED[4:0];
    restartIn <= 1'b1;
    @(posedge clock);
    restartIn <= 1'b0;
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge clock);
      #1;
      rises += int'(laneTxEnable === 1'b1 && !prevTx);
      prevTx = laneTxEnable;
      seenDone |= negotiation_done_out;
      flips += int'(laneTxLevel !== prevLevel);
      prevLevel = laneTxLevel;
    end
    check(32'(rises > 1), 32'h1);
    check(32'(seenDone), 32'h0);
    check(32'(flips > 48), 32'h1);
    $display("test equal nonce finished");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    negotiationEnable = 1'b0;
    restartIn = 1'b0;
    pcsRxStatus = 1'b0;
    trainDone = 1'b0;
    polySel = 2'h0;
    linkStatus = 4'h0;
    regAddr = 4'h0;
    regWriteData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    partnerOn = 1'b0;
    asmDir = 1'b0;
    page = '{fecBits: 2'h1, trainAbility: 1'b1, tech: 4'h6, spare: 20'h0,
      txNonce: 5'h03, np: 1'b0, ack: 1'b0, rf: 1'b0, pause: 3'h1,
      echoNonce: SEED[4:0], selector: `BPAN_SELECTOR};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    test_reset();
    negotiationEnable <= 1'b1;
    partnerOn <= 1'b1;
    for (int s = 0; s < 4; s++)
      test_negotiate(2'(s));
    test_carrier_loss();
    test_no_training();
    test_equal_nonce();
    print_verdict();
  end
endmodule // tb_top
